// File: verilog/scr_consts.svh
// Offsets, field positions, reset values and limits for the SDRAM config bank.
// Assumes inclusion by bare name from the design files.
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define SCR_GEOM_OFFSET     4'h8
`define SCR_REFRESH_OFFSET  4'hC

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define SCR_SELF_REFRESH_BIT  31
`define SCR_CAS_HI            11
`define SCR_CAS_LO            9
`define SCR_UNLOCK_BIT        8
`define SCR_BANK_HI           6
`define SCR_BANK_LO           4
`define SCR_COL_HI            2
`define SCR_COL_LO            0
`define SCR_RR_HI             12

// -----------------------------------------------------------------
// Reset values and limits
// -----------------------------------------------------------------
`define SCR_CAS_RESET    3'h3
`define SCR_BANK_RESET   3'h2
`define SCR_COL_RESET    3'h0
`define SCR_RR_RESET     13'h0190
`define SCR_RR_MIN       13'h0010
`define SCR_RR_SUBST     13'h0190
`define SCR_RESP_OKAY    2'h0
`define SCR_RESP_SLVERR  2'h2

`endif

// File: verilog/scr_pkg.sv
// Types for the SDRAM configuration and refresh register bank.
// Assumes the constants header is available on the include path.
package scr_pkg;

    typedef enum logic [1:0] {
        SCR_WR_IDLE = 2'b00,
        SCR_WR_RESP = 2'b01
    } scr_wr_state_t;

endpackage

// File: verilog/scr_regs.sv
// AXI4-Lite register bank: SDRAM geometry config and refresh interval.
// Assumes one clock aclk, synchronous active-low reset, single-beat access.
//
// Behaviour
// RULE1 - Three-bit latency field picks CAS latency two or three cycles.
// RULE2 - Latency updates only when the same write sets the unlock bit.
// RULE3 - Unlock bit keeps no state and always reads zero.
// RULE4 - Write touching latency, unlock, banks or columns starts initialization.
// RULE5 - Bank field codes one, two or four internal banks.
// RULE6 - Column field codes eight, nine or ten column address bits.
// RULE7 - Reserved bits read zero; software writes zero there.
// RULE8 - Thirteen-bit refresh interval counts memory clock cycles.
// RULE9 - Interval written below 0010h is stored as 0190h instead.
// RULE10 - Writing any low three config bytes starts initialization.
// RULE11 - Config bit 31 enters or leaves self-refresh.
// RULE12 - Refresh counter reloads from interval and pulses refresh request.
`timescale 1ns/1ns
`include "scr_consts.svh"

module scr_regs
    import scr_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [2:0]       cas_latency,
    output logic [2:0]       bank_count,
    output logic [2:0]       column_width,
    output logic             self_refresh,
    output logic             init_start,
    output logic             refresh_req
);

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    scr_wr_state_t wr_state_r;
    logic          aw_got_r;
    logic          w_got_r;
    logic [3:0]    aw_addr_r;
    logic [31:0]   w_data_r;
    logic [3:0]    w_strb_r;
    logic [2:0]    cas_r;
    logic [2:0]    bank_r;
    logic [2:0]    col_r;
    logic          sr_r;
    logic [12:0]   rr_r;
    logic [12:0]   rr_cnt_r;
    logic          init_r;
    logic          refresh_r;
    logic          wr_fire;
    logic          geom_hit;
    logic          refr_hit;
    logic [12:0]   rr_nxt;

    function automatic logic [31:0] scr_read(input logic [3:0] addr,
                                             input logic [2:0] cas,
                                             input logic [2:0] bank,
                                             input logic [2:0] col,
                                             input logic       sr,
                                             input logic [12:0] rr);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (addr == `SCR_GEOM_OFFSET) begin
            v[`SCR_SELF_REFRESH_BIT]    = sr;       // RULE11
            v[`SCR_CAS_HI:`SCR_CAS_LO]  = cas;
            v[`SCR_BANK_HI:`SCR_BANK_LO] = bank;
            v[`SCR_COL_HI:`SCR_COL_LO]  = col;
        end else if (addr == `SCR_REFRESH_OFFSET) begin
            v[`SCR_RR_HI:0] = rr;
        end
        // Unlock and reserved bits stay zero
        return v;                                   // RULE3 RULE7
    endfunction

    function automatic logic addr_mapped(input logic [3:0] addr);
        return (addr == `SCR_GEOM_OFFSET) || (addr == `SCR_REFRESH_OFFSET);
    endfunction

    // -----------------------------------------------------------------
    // Write channel
    // -----------------------------------------------------------------
    assign wr_fire  = (wr_state_r == SCR_WR_IDLE) && aw_got_r && w_got_r;
    assign geom_hit = wr_fire && (aw_addr_r == `SCR_GEOM_OFFSET);
    assign refr_hit = wr_fire && (aw_addr_r == `SCR_REFRESH_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            aw_addr_r     <= 4'h0;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_got_r      <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r      <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_got_r && (wr_state_r == SCR_WR_IDLE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_r      <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_got_r      <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_r      <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_got_r && (wr_state_r == SCR_WR_IDLE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r   <= SCR_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCR_RESP_OKAY;
        end else begin
            case (wr_state_r)
                SCR_WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_r   <= SCR_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= addr_mapped(aw_addr_r) ?
                                        `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
                    end
                end
                SCR_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_r   <= SCR_WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state_r   <= SCR_WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Geometry configuration register
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cas_r  <= `SCR_CAS_RESET;
            bank_r <= `SCR_BANK_RESET;
            col_r  <= `SCR_COL_RESET;
            sr_r   <= 1'b0;
        end else if (geom_hit) begin
            if (w_strb_r[1] && w_data_r[`SCR_UNLOCK_BIT]) begin
                cas_r <= w_data_r[`SCR_CAS_HI:`SCR_CAS_LO]; // RULE1 RULE2
            end
            if (w_strb_r[0]) begin
                bank_r <= w_data_r[`SCR_BANK_HI:`SCR_BANK_LO]; // RULE5
                col_r  <= w_data_r[`SCR_COL_HI:`SCR_COL_LO];   // RULE6
            end
            if (w_strb_r[3]) begin
                sr_r <= w_data_r[`SCR_SELF_REFRESH_BIT]; // RULE11
            end
        end
    end

    // Any low-byte lane starts init; a top-byte-only write does not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_r <= 1'b0;
        end else begin
            init_r <= geom_hit && (|w_strb_r[2:0]); // RULE4 RULE10
        end
    end

    // -----------------------------------------------------------------
    // Refresh interval register and counter
    // -----------------------------------------------------------------
    always_comb begin
        rr_nxt = w_data_r[`SCR_RR_HI:0];
        if (rr_nxt < `SCR_RR_MIN) begin
            rr_nxt = `SCR_RR_SUBST; // RULE9
        end
    end

    // Lane 0 or 1 loads the whole field; lanes are not merged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rr_r <= `SCR_RR_RESET;
        end else if (refr_hit && (|w_strb_r[1:0])) begin
            rr_r <= rr_nxt; // RULE8
        end
    end

    // Counter runs down; a new interval is picked up at the next reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rr_cnt_r  <= `SCR_RR_RESET;
            refresh_r <= 1'b0;
        end else if (rr_cnt_r == 13'h0000) begin
            rr_cnt_r  <= rr_r - 13'h0001; // RULE12
            refresh_r <= 1'b1;
        end else begin
            rr_cnt_r  <= rr_cnt_r - 13'h0001;
            refresh_r <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Read channel
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SCR_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= scr_read(s_axi_araddr, cas_r, bank_r, col_r,
                                      sr_r, rr_r);
            s_axi_rresp   <= addr_mapped(s_axi_araddr) ?
                             `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign cas_latency  = cas_r;
    assign bank_count   = bank_r;
    assign column_width = col_r;
    assign self_refresh = sr_r;
    assign init_start   = init_r;
    assign refresh_req  = refresh_r;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    cas_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (geom_hit && !w_data_r[`SCR_UNLOCK_BIT]) |=> $stable(cas_r))
        else $error("latency changed without unlock"); // RULE2

    cas_unlocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (geom_hit && w_strb_r[1] && w_data_r[`SCR_UNLOCK_BIT])
        |=> cas_r == $past(w_data_r[`SCR_CAS_HI:`SCR_CAS_LO]))
        else $error("latency not taken with unlock"); // RULE1

    // Keyed on the address: bit 8 of the refresh word is interval data
    unlock_reads_zero_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready
         && s_axi_araddr == `SCR_GEOM_OFFSET)
        |=> !s_axi_rdata[`SCR_UNLOCK_BIT])
        else $error("unlock bit read as one"); // RULE3

    init_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (geom_hit && (|w_strb_r[2:0])) |=> init_start)
        else $error("init not started by config write"); // RULE4

    init_top_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (geom_hit && w_strb_r == 4'h8) |=> !init_start)
        else $error("init started by top byte write"); // RULE10

    geom_fields_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (geom_hit && w_strb_r[0]) |=> (bank_r == $past(w_data_r[6:4]))
        && (col_r == $past(w_data_r[2:0])))
        else $error("bank or column field not stored"); // RULE5 RULE6

    rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready
         && s_axi_araddr == `SCR_GEOM_OFFSET)
        |=> (s_axi_rdata[30:12] == 19'h0)
        && !s_axi_rdata[7] && !s_axi_rdata[3])
        else $error("reserved bits read nonzero"); // RULE7

    rr_rsvd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready
         && s_axi_araddr == `SCR_REFRESH_OFFSET)
        |=> (s_axi_rdata[31:13] == 19'h0))
        else $error("refresh upper bits read nonzero"); // RULE7

    rr_subst_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (refr_hit && w_strb_r[0] && w_strb_r[1]
         && w_data_r[12:0] < `SCR_RR_MIN) |=> rr_r == `SCR_RR_SUBST)
        else $error("small interval not replaced"); // RULE9

    sr_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (geom_hit && w_strb_r[3]) |=> sr_r == $past(w_data_r[31]))
        else $error("self-refresh bit not stored"); // RULE11

    refresh_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        refresh_req |-> ##1 !refresh_req)
        else $error("refresh request not a pulse"); // RULE12 RULE8

endmodule

// File: verification/scr_sdram_model.sv
// SDRAM stand-in: counts init commands and times refresh requests.
// Assumes one-cycle command pulses on aclk.
`timescale 1ns/1ns
module scr_sdram_model (
    input  wire logic aclk,
    input  wire logic init_start,
    input  wire logic refresh_req,
    output int        init_cnt,
    output int        ref_gap
);
    int age = 0;
    initial init_cnt = 0;
    initial ref_gap = 0;
    // Gap is kept per request, so a changed interval shows one reload later
    always @(posedge aclk) begin
        age <= refresh_req ? 1 : age + 1;
        if (refresh_req)
            ref_gap <= age;
        if (init_start)
            init_cnt <= init_cnt + 1;
    end
endmodule

// File: verification/sdram_config_refresh_regs_tb.sv
// Bench for the SDRAM config and refresh bank, with a field model.
// Assumes scr_regs, scr_sdram_model and the constants header.
`timescale 1ns/1ns
`include "scr_consts.svh"
module sdram_config_refresh_regs_tb;
    logic        aclk, aresetn, aw_v, w_v, b_rdy, ar_v, r_rdy;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, sref, init, refr;
    logic [3:0]  aw_a, w_s, ar_a, a;
    logic [31:0] w_d, r_d, d;
    logic [1:0]  b_resp, r_resp;
    logic [2:0]  cas, bank, col;
    int          bad_count, num_checks, seed, i, init_cnt, ref_gap;
    int          m_cas, m_bank, m_col, m_sr, m_rr, m_init;
    int          rr_set[6] = '{0, 5, 'hF, 'h10, 'h1FFF, -1};

    scr_regs dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v),
        .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .cas_latency(cas),
        .bank_count(bank), .column_width(col), .self_refresh(sref),
        .init_start(init), .refresh_req(refr));
    scr_sdram_model mem_u (.aclk(aclk), .init_start(init),
        .refresh_req(refr), .init_cnt(init_cnt), .ref_gap(ref_gap));

    // -----------------------------------------------------------------
    // Bus tasks and checks
    // -----------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // Bounded wait: a hung handshake ends the run
    task automatic step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 50) begin
            bad_count++;
            report_and_stop;
        end
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        {m_cas, m_bank, m_col, m_sr} = {32'd3, 32'd2, 64'd0};
        m_rr = `SCR_RR_RESET;
        @(posedge aclk);
    endtask

    task automatic wr(input logic [3:0] ad, input logic [31:0] dt,
                      input logic [3:0] st);
        int n;
        logic ta, tw, ok;
        {n, ta, tw} = 0;
        ok = ad == `SCR_GEOM_OFFSET || ad == `SCR_REFRESH_OFFSET;
        {aw_a, w_d, w_s, aw_v, w_v, b_rdy} <= {ad, dt, st, 3'b111};
        do begin
            step(n);
            ta |= aw_rdy;
            tw |= w_rdy;
            {aw_v, w_v} <= {aw_v & ~ta, w_v & ~tw};
        end while (!(ta && tw && b_v));
        b_rdy <= 1'b0;
        chk(b_resp, ok ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR);
        if (ad == `SCR_GEOM_OFFSET) begin
            m_bank = st[0] ? dt[6:4] : m_bank;
            m_col = st[0] ? dt[2:0] : m_col;
            m_cas = st[1] && dt[8] ? dt[11:9] : m_cas;
            m_sr = st[3] ? dt[31] : m_sr;
            m_init += |st[2:0];
        end
        if (ad == `SCR_REFRESH_OFFSET && |st[1:0])
            m_rr = dt[12:0] < `SCR_RR_MIN ? `SCR_RR_SUBST : dt[12:0];
        repeat (2) @(posedge aclk);
        chk(cas, m_cas);
        chk(bank, m_bank);
        chk(col, m_col);
        chk(sref, m_sr);
        chk(init_cnt, m_init);
    endtask

    task automatic rd(input logic [3:0] ad);
        int n;
        logic ok;
        logic [31:0] e;
        n = 0;
        ok = ad == `SCR_GEOM_OFFSET || ad == `SCR_REFRESH_OFFSET;
        {ar_a, ar_v, r_rdy} <= {ad, 2'b11};
        do step(n); while (!ar_rdy);
        ar_v <= 1'b0;
        do step(n); while (!r_v);
        r_rdy <= 1'b0;
        e = ad[2] ? m_rr : m_sr << 31 | m_cas << 9 | m_bank << 4 | m_col;
        chk(r_d, ok ? e : 32'h0);
        chk(r_resp, ok ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR);
        @(posedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        {aw_v, w_v, b_rdy, ar_v, r_rdy, aw_a, ar_a, w_s, w_d} = 49'h0;
        {bad_count, num_checks, m_init} = 96'h0;
        seed = 30202;
        do_reset;
        rd(`SCR_GEOM_OFFSET);
        rd(`SCR_REFRESH_OFFSET);
        rd(4'h4);
        wr(4'h0, 32'hFFFF_FFFF, 4'hF);
        wr(`SCR_GEOM_OFFSET, 32'h0000_0400, 4'h3);
        for (i = 0; i < 8; i++) begin
            d = 32'h100 | i << 9 | i << 4 | i;
            wr(`SCR_GEOM_OFFSET, d, 4'h3);
            rd(`SCR_GEOM_OFFSET);
        end
        wr(`SCR_GEOM_OFFSET, 32'hFFFF_FFFF, 4'hF);
        rd(`SCR_GEOM_OFFSET);
        wr(`SCR_GEOM_OFFSET, 32'h0000_0000, 4'h8);
        wr(`SCR_GEOM_OFFSET, 32'h0000_0000, 4'h4);
        for (i = 0; i < 6; i++) begin
            wr(`SCR_REFRESH_OFFSET, rr_set[i], 4'hF);
            rd(`SCR_REFRESH_OFFSET);
        end
        for (i = 0; i < 30; i++) begin
            a = $random(seed) & 1 ? `SCR_GEOM_OFFSET : `SCR_REFRESH_OFFSET;
            d = $random(seed) & (a[2] ? 32'h0000_1FFF : 32'h8000_0F77);
            wr(a, d, 4'($random(seed)));
            rd(a);
        end
        do_reset;
        rd(`SCR_GEOM_OFFSET);
        wr(`SCR_REFRESH_OFFSET, 32'h0000_0010, 4'h3);
        repeat (500) @(posedge aclk);
        chk(ref_gap, 32'h10);
        report_and_stop;
    end
endmodule
